// File: design/ssi_irq_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// RL1: Events are only taken once the device reports normal operating mode.
// RL2: Register 02 reads rail faults, bit 7 first buck to bit 0 fifth linreg.
// RL3: ADC out-of-range kept as internal status only, no readable bit.
// RL4: Analog input high-impedance kept as internal status only.
// RL5: Thermal fault is an internal status that can raise an interrupt.
// RL6: Interrupt request drives the active-low interrupt line low.
// RL7: Register 03 masks per-rail fault interrupts; 1 blocks, 0 allows.
// RL8: Register 04 bit 7 blocks the conversion-done interrupt.
// RL9: Register 04 bit 6 blocks the high-impedance interrupt.
// RL10: Register 04 bits 5 and 4 block GPIO two and one edge interrupts.
// RL11: Register 04 bit 3 blocks the thermal fault interrupt.
// RL12: Register 04 bit 2 blocks charger status change interrupts.
// RL13: Register 04 bits 1 and 0 block ADC above-high and below-low interrupts.
// RL14: Flag bits read 1 for the causing source; writing 0 clears a flag.
// RL15: While the line is low, flags are frozen and new events ignored.
// RL16: Host writes 0 to the causing flag to release the line.
// RL17: Masks and flags reset to all zeros.

module ssi_irq_ctrl #(
    parameter logic [6:0] DEV_ADDR = ssi_pkg::DEF_DEV_ADDR
) (
    input  wire logic             clk_sys,
    input  wire logic             reset_n,
    input  wire logic             normal_mode,
    input  wire ssi_pkg::ssi_src_t src_in,
    input  wire logic             scl_in,
    input  wire logic             sda_in,
    output logic                  sda_out,
    output logic                  sda_oe,
    output logic                  int_n
);

    // Synchronised pins and sources
    ssi_pkg::ssi_src_t src_s;
    logic [1:0]        bus_s;
    logic              scl_s;
    logic              sda_s;

    // Serial slave state
    ssi_pkg::ssi_state_t st_ff,       nxt_st;
    logic [2:0]          bit_cnt_ff,  nxt_bit_cnt;
    logic [7:0]          shift_ff,    nxt_shift;
    logic [7:0]          ptr_ff,      nxt_ptr;
    logic                first_ff,    nxt_first;
    logic                rw_ff,       nxt_rw;
    logic                sda_oe_ff,   nxt_sda_oe;
    logic                scl_d_ff;
    logic                sda_d_ff;
    logic                wr_stb;
    logic [7:0]          rd_data;

    // Register and interrupt state
    logic [7:0]          fault_mask_ff, nxt_fault_mask;
    logic [7:0]          misc_mask_ff,  nxt_misc_mask;
    logic [7:0]          fault_ack_ff,  nxt_fault_ack;
    logic [7:0]          misc_ack_ff,   nxt_misc_ack;
    logic                irq_act_ff,    nxt_irq_act;
    ssi_pkg::ssi_src_t   src_d_ff;
    logic [7:0]          fault_evt;
    logic [7:0]          misc_evt;
    logic [7:0]          fault_req;
    logic [7:0]          misc_req;

    // Internal status levels with no register bit
    logic                adc_out_of_range;
    logic                hi_z_status;
    logic                thermal_status;

    // Serial pins idle high, so their chain resets high to avoid a false start
    ssi_sync3 #(
        .WIDTH     (2),
        .RESET_VAL (2'h3)
    ) u_bus_sync (
        .clk_sys  (clk_sys),
        .reset_n  (reset_n),
        .async_in ({scl_in, sda_in}),
        .sync_out (bus_s)
    );

    // Sources come from analog comparators and pins, hence synchronised
    ssi_sync3 #(
        .WIDTH     (ssi_pkg::SRC_W),
        .RESET_VAL ('0)
    ) u_src_sync (
        .clk_sys  (clk_sys),
        .reset_n  (reset_n),
        .async_in (src_in),
        .sync_out (src_s)
    );

    assign scl_s = bus_s[1];
    assign sda_s = bus_s[0];

    // Internal status kept for other logic, not mapped to any register
    assign adc_out_of_range = src_s.conv_high | src_s.conv_low; // [RL3]
    assign hi_z_status      = src_s.hi_z;                       // [RL4]
    assign thermal_status   = src_s.thermal;                    // [RL5]

    // Register read mux; unmapped addresses read zero
    always_comb
    begin
        if (ptr_ff == ssi_pkg::ADDR_RAIL_HEALTH)
            rd_data = src_s.rail_fault; // [RL2]
        else if (ptr_ff == ssi_pkg::ADDR_FAULT_MASK)
            rd_data = fault_mask_ff;
        else if (ptr_ff == ssi_pkg::ADDR_MISC_MASK)
            rd_data = misc_mask_ff;
        else if (ptr_ff == ssi_pkg::ADDR_FAULT_ACK)
            rd_data = fault_ack_ff;
        else if (ptr_ff == ssi_pkg::ADDR_MISC_ACK)
            rd_data = misc_ack_ff;
        else
            rd_data = ssi_pkg::RST_BYTE;
    end

    // Serial slave next state: sample on SCL rise, drive SDA after SCL fall
    always_comb
    begin
        logic rise;
        logic fall;
        logic start;
        logic stop;
        rise        = !scl_d_ff && scl_s;
        fall        = scl_d_ff && !scl_s;
        start       = scl_d_ff && scl_s && sda_d_ff && !sda_s;
        stop        = scl_d_ff && scl_s && !sda_d_ff && sda_s;
        nxt_st      = st_ff;
        nxt_bit_cnt = bit_cnt_ff;
        nxt_shift   = shift_ff;
        nxt_ptr     = ptr_ff;
        nxt_first   = first_ff;
        nxt_rw      = rw_ff;
        nxt_sda_oe  = sda_oe_ff;
        wr_stb      = 1'b0;
        if (start)
        begin
            nxt_st      = ssi_pkg::ST_ADDR;
            nxt_bit_cnt = ssi_pkg::RST_BIT_CNT;
            nxt_sda_oe  = 1'b0;
        end
        else if (stop)
        begin
            nxt_st     = ssi_pkg::ST_IDLE;
            nxt_sda_oe = 1'b0;
        end
        else
        begin
            case (st_ff)
                ssi_pkg::ST_ADDR, ssi_pkg::ST_WR_BYTE:
                    if (rise)
                    begin
                        nxt_shift   = {shift_ff[6:0], sda_s};
                        nxt_bit_cnt = bit_cnt_ff + 3'h1;
                        if (bit_cnt_ff == ssi_pkg::LAST_BIT)
                            nxt_st = (st_ff == ssi_pkg::ST_ADDR) ? ssi_pkg::ST_ADDR_END
                                                                 : ssi_pkg::ST_WR_END;
                    end
                ssi_pkg::ST_ADDR_END:
                    if (fall)
                    begin
                        if (shift_ff[7:1] == DEV_ADDR)
                        begin
                            nxt_sda_oe = 1'b1;
                            nxt_rw     = shift_ff[0];
                            nxt_st     = ssi_pkg::ST_ADDR_ACK;
                        end
                        else
                            nxt_st = ssi_pkg::ST_IDLE;
                    end
                ssi_pkg::ST_WR_END:
                    if (fall)
                    begin
                        nxt_sda_oe = 1'b1;
                        nxt_st     = ssi_pkg::ST_WR_ACK;
                        nxt_first  = 1'b0;
                        if (first_ff)
                            nxt_ptr = shift_ff;
                        else
                        begin
                            wr_stb  = 1'b1;
                            nxt_ptr = ptr_ff + 8'h01;
                        end
                    end
                ssi_pkg::ST_WR_ACK:
                    if (fall)
                    begin
                        nxt_sda_oe  = 1'b0;
                        nxt_bit_cnt = ssi_pkg::RST_BIT_CNT;
                        nxt_st      = ssi_pkg::ST_WR_BYTE;
                    end
                ssi_pkg::ST_ADDR_ACK, ssi_pkg::ST_RD_NEXT:
                    if (fall)
                    begin
                        nxt_bit_cnt = ssi_pkg::RST_BIT_CNT;
                        if (st_ff == ssi_pkg::ST_ADDR_ACK && !rw_ff)
                        begin
                            nxt_sda_oe = 1'b0;
                            nxt_first  = 1'b1;
                            nxt_st     = ssi_pkg::ST_WR_BYTE;
                        end
                        else
                        begin
                            // Byte is sampled here, so it cannot tear mid-transfer
                            nxt_shift  = rd_data;
                            nxt_sda_oe = !rd_data[7];
                            nxt_ptr    = ptr_ff + 8'h01;
                            nxt_st     = ssi_pkg::ST_RD_BYTE;
                        end
                    end
                ssi_pkg::ST_RD_BYTE:
                    if (rise)
                    begin
                        nxt_bit_cnt = bit_cnt_ff + 3'h1;
                        if (bit_cnt_ff == ssi_pkg::LAST_BIT)
                            nxt_st = ssi_pkg::ST_RD_END;
                    end
                    else if (fall)
                    begin
                        nxt_shift  = {shift_ff[6:0], 1'b0};
                        nxt_sda_oe = !shift_ff[6];
                    end
                ssi_pkg::ST_RD_END:
                    if (fall)
                    begin
                        nxt_sda_oe = 1'b0;
                        nxt_st     = ssi_pkg::ST_RD_ACK;
                    end
                ssi_pkg::ST_RD_ACK:
                    if (rise)
                        nxt_st = sda_s ? ssi_pkg::ST_IDLE : ssi_pkg::ST_RD_NEXT;
                default:
                    nxt_st = ssi_pkg::ST_IDLE;
            endcase
        end
    end

    // Serial slave registers
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st_ff      <= ssi_pkg::ST_IDLE;
            bit_cnt_ff <= ssi_pkg::RST_BIT_CNT;
            shift_ff   <= ssi_pkg::RST_BYTE;
            ptr_ff     <= ssi_pkg::RST_BYTE;
            first_ff   <= 1'b0;
            rw_ff      <= 1'b0;
            sda_oe_ff  <= 1'b0;
            scl_d_ff   <= 1'b1;
            sda_d_ff   <= 1'b1;
        end
        else
        begin
            st_ff      <= nxt_st;
            bit_cnt_ff <= nxt_bit_cnt;
            shift_ff   <= nxt_shift;
            ptr_ff     <= nxt_ptr;
            first_ff   <= nxt_first;
            rw_ff      <= nxt_rw;
            sda_oe_ff  <= nxt_sda_oe;
            scl_d_ff   <= scl_s;
            sda_d_ff   <= sda_s;
        end
    end

    // Open drain: only ever pulls low
    assign sda_out = 1'b0;
    assign sda_oe  = sda_oe_ff;

    // Source changes; conversion done counts on its rising edge only
    always_comb
    begin
        fault_evt                         = src_s.rail_fault ^ src_d_ff.rail_fault;
        misc_evt                          = 8'h00;
        misc_evt[ssi_pkg::BIT_CONV_DONE]  = src_s.conv_done & ~src_d_ff.conv_done;
        misc_evt[ssi_pkg::BIT_HI_Z]       = hi_z_status ^ src_d_ff.hi_z;
        misc_evt[ssi_pkg::BIT_GP_TWO]     = src_s.gp_pin_two ^ src_d_ff.gp_pin_two;
        misc_evt[ssi_pkg::BIT_GP_ONE]     = src_s.gp_pin_one ^ src_d_ff.gp_pin_one;
        misc_evt[ssi_pkg::BIT_THERMAL]    = thermal_status ^ src_d_ff.thermal;
        misc_evt[ssi_pkg::BIT_CHARGER]    = |(src_s.charger_state_reg
                                              ^ src_d_ff.charger_state_reg);
        misc_evt[ssi_pkg::BIT_CONV_HIGH]  = src_s.conv_high ^ src_d_ff.conv_high;
        misc_evt[ssi_pkg::BIT_CONV_LOW]   = src_s.conv_low ^ src_d_ff.conv_low;
        // A mask bit of 1 blocks; nothing counts before normal mode
        fault_req = normal_mode ? (fault_evt & ~fault_mask_ff) : 8'h00; // [RL1] [RL7]
        misc_req  = normal_mode ? (misc_evt & ~misc_mask_ff) : 8'h00;   // [RL1] [RL8] [RL9]
    end // misc_mask_ff bits 5..0 gate GPIO, thermal, charger, range [RL10] [RL11] [RL12] [RL13]

    // Mask writes, flag capture and clearing, line control
    always_comb
    begin
        logic [7:0] ack1_clr;
        logic [7:0] ack2_clr;
        ack1_clr       = fault_ack_ff;
        ack2_clr       = misc_ack_ff;
        nxt_fault_mask = fault_mask_ff;
        nxt_misc_mask  = misc_mask_ff;
        if (wr_stb && ptr_ff == ssi_pkg::ADDR_FAULT_MASK)
            nxt_fault_mask = shift_ff; // [RL7]
        else if (wr_stb && ptr_ff == ssi_pkg::ADDR_MISC_MASK)
            nxt_misc_mask = shift_ff; // [RL8]
        else if (wr_stb && ptr_ff == ssi_pkg::ADDR_FAULT_ACK)
            ack1_clr = fault_ack_ff & shift_ff; // [RL14]
        else if (wr_stb && ptr_ff == ssi_pkg::ADDR_MISC_ACK)
            ack2_clr = misc_ack_ff & shift_ff; // [RL14]
        nxt_fault_ack = ack1_clr;
        nxt_misc_ack  = ack2_clr;
        nxt_irq_act   = irq_act_ff;
        if (!irq_act_ff || (ack1_clr == 8'h00 && ack2_clr == 8'h00))
        begin
            // Released or idle: new events load the flags; set wins over clear
            nxt_fault_ack = fault_req | ack1_clr; // [RL14] [RL16]
            nxt_misc_ack  = misc_req | ack2_clr;
            nxt_irq_act   = (fault_req != 8'h00) || (misc_req != 8'h00); // [RL6]
        end
        // Otherwise the line is low: flags frozen except host clears [RL15]
    end

    // Interrupt and register state; all masks and flags reset clear
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            fault_mask_ff <= ssi_pkg::RST_FAULT_MASK; // [RL17]
            misc_mask_ff  <= ssi_pkg::RST_MISC_MASK;
            fault_ack_ff  <= ssi_pkg::RST_ACK;
            misc_ack_ff   <= ssi_pkg::RST_ACK;
            irq_act_ff    <= 1'b0;
            src_d_ff      <= '0;
        end
        else
        begin
            fault_mask_ff <= nxt_fault_mask;
            misc_mask_ff  <= nxt_misc_mask;
            fault_ack_ff  <= nxt_fault_ack;
            misc_ack_ff   <= nxt_misc_ack;
            irq_act_ff    <= nxt_irq_act;
            src_d_ff      <= src_s;
        end
    end

    // Line is low exactly while a request is pending
    assign int_n = !irq_act_ff; // [RL6]

endmodule : ssi_irq_ctrl

`default_nettype wire

// File: design/ssi_pkg.sv
package ssi_pkg;

    // Register addresses on the serial port
    localparam logic [7:0] ADDR_RAIL_HEALTH = 8'h02;
    localparam logic [7:0] ADDR_FAULT_MASK  = 8'h03;
    localparam logic [7:0] ADDR_MISC_MASK   = 8'h04;
    localparam logic [7:0] ADDR_FAULT_ACK   = 8'h05;
    localparam logic [7:0] ADDR_MISC_ACK    = 8'h06;

    // Values after reset
    localparam logic [7:0] RST_FAULT_MASK = 8'h00;
    localparam logic [7:0] RST_MISC_MASK  = 8'h00;
    localparam logic [7:0] RST_ACK        = 8'h00;
    localparam logic [7:0] RST_BYTE       = 8'h00;
    localparam logic [2:0] RST_BIT_CNT    = 3'h0;

    // Bit positions in the misc mask and misc flag registers
    localparam int BIT_CONV_DONE = 7;
    localparam int BIT_HI_Z      = 6;
    localparam int BIT_GP_TWO    = 5;
    localparam int BIT_GP_ONE    = 4;
    localparam int BIT_THERMAL   = 3;
    localparam int BIT_CHARGER   = 2;
    localparam int BIT_CONV_HIGH = 1;
    localparam int BIT_CONV_LOW  = 0;

    // Bit counter value of the last bit in a byte
    localparam logic [2:0] LAST_BIT = 3'h7;

    // Serial port defaults; device address value is arbitrary
    localparam logic [6:0] DEF_DEV_ADDR = 7'h2a;

    // Raw event and status sources, bit 7 of rail_fault is the first buck
    typedef struct packed {
        logic [7:0] rail_fault;
        logic       conv_done;
        logic       hi_z;
        logic       gp_pin_two;
        logic       gp_pin_one;
        logic       thermal;
        logic [7:0] charger_state_reg;
        logic       conv_high;
        logic       conv_low;
    } ssi_src_t;

    localparam int SRC_W = $bits(ssi_src_t);

    // Serial slave states
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_END,
        ST_ADDR_ACK,
        ST_WR_BYTE,
        ST_WR_END,
        ST_WR_ACK,
        ST_RD_BYTE,
        ST_RD_END,
        ST_RD_ACK,
        ST_RD_NEXT
    } ssi_state_t;

endpackage : ssi_pkg

// File: design/ssi_sync3.sv
`timescale 1ns/1ps
`default_nettype none

module ssi_sync3 #(
    parameter int               WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input  wire logic             clk_sys,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] mid_ff;
    logic [WIDTH-1:0] late_ff;
    logic [WIDTH-1:0] held_ff;
    logic [WIDTH-1:0] nxt_held;

    // Accept a bit only when stages two and three agree, filtering glitches
    always_comb
    begin
        for (int i = 0; i < WIDTH; i++)
        begin
            nxt_held[i] = (mid_ff[i] == late_ff[i]) ? late_ff[i] : held_ff[i];
        end
    end

    // Three-stage chain; the first stage feeds only the second
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            meta_ff <= RESET_VAL;
            mid_ff  <= RESET_VAL;
            late_ff <= RESET_VAL;
            held_ff <= RESET_VAL;
        end
        else
        begin
            meta_ff <= async_in;
            mid_ff  <= meta_ff;
            late_ff <= mid_ff;
            held_ff <= nxt_held;
        end
    end

    assign sync_out = held_ff;

endmodule : ssi_sync3

`default_nettype wire

// File: verification/ssi_irq_ctrl_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module ssi_irq_ctrl_asserts (
    input wire logic              clk_sys,
    input wire logic              reset_n,
    input wire logic              normal_mode,
    input wire ssi_pkg::ssi_src_t src_in,
    input wire logic              scl_in,
    input wire logic              sda_in,
    input wire logic              sda_out,
    input wire logic              sda_oe,
    input wire logic              int_n
);
    logic [3:0]        chg_cnt_ff;
    logic [3:0]        nxt_chg_cnt;
    logic [3:0]        fall_cnt_ff;
    logic [3:0]        nxt_fall_cnt;
    ssi_pkg::ssi_src_t src_q_ff;
    logic              scl_q_ff;

    // Cycles since a source moved and since the bus clock fell, saturating
    always_comb
    begin
        nxt_chg_cnt  = (src_in != src_q_ff) ? 4'h0 : chg_cnt_ff + {3'h0, chg_cnt_ff != 4'hf};
        nxt_fall_cnt = (scl_q_ff && !scl_in) ? 4'h0 : fall_cnt_ff + {3'h0, fall_cnt_ff != 4'hf};
    end

    // Reset counts as a source change, since the sync chain restarts at zero
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            chg_cnt_ff  <= 4'h0;
            fall_cnt_ff <= 4'hf;
            src_q_ff    <= '0;
            scl_q_ff    <= 1'b1;
        end
        else
        begin
            chg_cnt_ff  <= nxt_chg_cnt;
            fall_cnt_ff <= nxt_fall_cnt;
            src_q_ff    <= src_in;
            scl_q_ff    <= scl_in;
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);

    sequence s_scl_low3;
        !scl_in [*3];
    endsequence
    property p_rst_idle;
        $rose(reset_n) |-> int_n && !sda_oe;
    endproperty
    property p_mode_hold;
        int_n && !normal_mode |=> int_n;
    endproperty
    property p_fall_mode;
        $fell(int_n) |-> $past(normal_mode);
    endproperty
    property p_fall_cause;
        $fell(int_n) |-> chg_cnt_ff <= 4'h8;
    endproperty
    property p_rose_cause;
        $rose(int_n) |-> fall_cnt_ff <= 4'h9;
    endproperty
    property p_oe_edge;
        $changed(sda_oe) |-> !$past(scl_in, 2);
    endproperty
    property p_oe_rise;
        $rose(sda_oe) |-> s_scl_low3;
    endproperty
    property p_drv_zero;
        sda_out == 1'b0 && (!sda_oe || !sda_in);
    endproperty

    a_rst_idle: assert property (p_rst_idle) else $error("lines not idle after reset");
    a_mode_hold: assert property (p_mode_hold) else $error("irq outside normal mode");
    a_fall_mode: assert property (p_fall_mode) else $error("irq without normal mode");
    a_fall_cause: assert property (p_fall_cause) else $error("irq without source change");
    a_rose_cause: assert property (p_rose_cause) else $error("irq released off bus");
    a_oe_edge: assert property (p_oe_edge) else $error("data drive moved in clock high");
    a_oe_rise: assert property (p_oe_rise) else $error("data drive started late");
    a_drv_zero: assert property (p_drv_zero) else $error("data line driven high");
endmodule : ssi_irq_ctrl_asserts

bind ssi_irq_ctrl ssi_irq_ctrl_asserts ssi_irq_ctrl_asserts_i (
    .clk_sys     (clk_sys),
    .reset_n     (reset_n),
    .normal_mode (normal_mode),
    .src_in      (src_in),
    .scl_in      (scl_in),
    .sda_in      (sda_in),
    .sda_out     (sda_out),
    .sda_oe      (sda_oe),
    .int_n       (int_n)
);

`default_nettype wire

// File: verification/ssi_i2c_host.sv
`timescale 1ns/1ps
`default_nettype none

// Host end of the two-wire bus; drives the clock high and low, only pulls data low, the pull-up gives its high
module ssi_i2c_host (
    input  wire logic clk_sys,
    input  wire logic sda,
    output var logic  scl,
    output var logic  sda_pull
);
    localparam logic [7:0] ADDR_W = {ssi_pkg::DEF_DEV_ADDR, 1'b0};

    initial
    begin
        scl      = 1'b1;
        sda_pull = 1'b0;
    end

    task automatic hp(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : hp

    // Data moves two clocks after the fall, so the one bus synchroniser sees the fall first
    task automatic xbit(input logic b, output logic r);
        sda_pull <= !b;
        hp(10);
        scl <= 1'b1;
        hp(5);
        r = sda;
        hp(5);
        scl <= 1'b0;
        hp(2);
    endtask : xbit

    // Serves as first and repeated start alike
    task automatic start();
        sda_pull <= 1'b0;
        hp(4);
        scl <= 1'b1;
        hp(10);
        sda_pull <= 1'b1;
        hp(10);
        scl <= 1'b0;
        hp(2);
    endtask : start

    task automatic stop();
        sda_pull <= 1'b1;
        hp(10);
        scl <= 1'b1;
        hp(10);
        sda_pull <= 1'b0;
        hp(10);
    endtask : stop

    // Ninth bit always released: device ack on writes, host nack on reads
    task automatic xbyte(input logic [7:0] d, output logic [7:0] q, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            xbit(d[i], r);
            q[i] = r;
        end
        xbit(1'b1, r);
        ack = !r;
    endtask : xbyte

    task automatic write_reg(input logic [7:0] a, input logic [7:0] d, output logic ok);
        logic [7:0] q;
        logic       k1;
        logic       k2;
        logic       k3;
        start();
        xbyte(ADDR_W, q, k1);
        xbyte(a, q, k2);
        xbyte(d, q, k3);
        stop();
        ok = k1 & k2 & k3;
    endtask : write_reg

    task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
        logic [7:0] q;
        logic       k1;
        logic       k2;
        logic       k3;
        logic       k4;
        start();
        xbyte(ADDR_W, q, k1);
        xbyte(a, q, k2);
        start();
        xbyte(ADDR_W | 8'h01, q, k3);
        xbyte(8'hff, d, k4);
        stop();
        ok = k1 & k2 & k3;
    endtask : read_reg
endmodule : ssi_i2c_host

`default_nettype wire

// File: verification/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic                      clk_sys;
    logic                      reset_n;
    logic                      normal_mode;
    logic [ssi_pkg::SRC_W-1:0] src_v;
    logic                      scl;
    logic                      h_pull;
    logic                      sda_out;
    logic                      sda_oe;
    logic                      int_n;
    logic                      sda;
    int                        fails;
    int                        checked;

    // Open-drain wire with pull-up
    assign sda = !(h_pull || sda_oe);

    ssi_irq_ctrl ssi_irq_ctrl_i (
        .clk_sys     (clk_sys),
        .reset_n     (reset_n),
        .normal_mode (normal_mode),
        .src_in      (ssi_pkg::ssi_src_t'(src_v)),
        .scl_in      (scl),
        .sda_in      (sda),
        .sda_out     (sda_out),
        .sda_oe      (sda_oe),
        .int_n       (int_n)
    );

    ssi_i2c_host ssi_i2c_host_i (
        .clk_sys  (clk_sys),
        .sda      (sda),
        .scl      (scl),
        .sda_pull (h_pull)
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string msg);
        checked++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : cmp8

    task automatic cmp1(input logic got, input logic exp, input string msg);
        checked++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED %0t %s got %b exp %b", $time, msg, got, exp);
        end
    endtask : cmp1

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic ok;
        ssi_i2c_host_i.write_reg(a, d, ok);
        cmp1(ok, 1'b1, "write not acked");
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic       ok;
        ssi_i2c_host_i.read_reg(a, d, ok);
        cmp1(ok, 1'b1, "read not acked");
        cmp8(d, exp, "read data");
    endtask : rd

    // Twelve clocks covers sync plus flag latency with margin
    task automatic chg(input int idx, input logic v, input logic exp_int);
        @(posedge clk_sys);
        src_v[idx] <= v;
        repeat (12) @(posedge clk_sys);
        cmp1(int_n, exp_int, "irq line");
    endtask : chg

    task automatic wrap_up();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : wrap_up

    // Main sequence; bit 22 of the source vector is the first buck
    initial
    begin
        int idx;
        reset_n     = 1'b0;
        normal_mode = 1'b0;
        src_v       = '0;
        fails       = 0;
        checked     = 0;
        repeat (16) @(posedge clk_sys);
        reset_n     <= 1'b1;
        normal_mode <= 1'b1;
        repeat (8) @(posedge clk_sys);
        cmp1(int_n, 1'b1, "irq idle");
        rd(ssi_pkg::ADDR_FAULT_MASK, ssi_pkg::RST_FAULT_MASK);
        rd(ssi_pkg::ADDR_MISC_MASK, ssi_pkg::RST_MISC_MASK);
        rd(ssi_pkg::ADDR_FAULT_ACK, ssi_pkg::RST_ACK);
        rd(ssi_pkg::ADDR_MISC_ACK, ssi_pkg::RST_ACK);
        wr(ssi_pkg::ADDR_FAULT_MASK, 8'ha5);
        rd(ssi_pkg::ADDR_FAULT_MASK, 8'ha5);
        wr(ssi_pkg::ADDR_MISC_MASK, 8'h5a);
        rd(ssi_pkg::ADDR_MISC_MASK, 8'h5a);
        wr(ssi_pkg::ADDR_RAIL_HEALTH, 8'hff);
        rd(ssi_pkg::ADDR_RAIL_HEALTH, 8'h00);
        rd(8'h10, 8'h00);
        wr(ssi_pkg::ADDR_FAULT_MASK, 8'h00);
        wr(ssi_pkg::ADDR_MISC_MASK, 8'hff);
        // Events outside normal mode are dropped
        @(posedge clk_sys);
        normal_mode <= 1'b0;
        chg(22, 1'b1, 1'b1);
        chg(22, 1'b0, 1'b1);
        @(posedge clk_sys);
        normal_mode <= 1'b1;
        rd(ssi_pkg::ADDR_FAULT_ACK, 8'h00);
        // Rail fault raises, then flags freeze while the line is low
        chg(22, 1'b1, 1'b0);
        rd(ssi_pkg::ADDR_FAULT_ACK, 8'h80);
        rd(ssi_pkg::ADDR_RAIL_HEALTH, 8'h80);
        chg(15, 1'b1, 1'b0);
        rd(ssi_pkg::ADDR_FAULT_ACK, 8'h80);
        wr(ssi_pkg::ADDR_FAULT_ACK, 8'h00);
        repeat (12) @(posedge clk_sys);
        cmp1(int_n, 1'b1, "irq release");
        rd(ssi_pkg::ADDR_FAULT_ACK, 8'h00);
        wr(ssi_pkg::ADDR_FAULT_ACK, 8'hff);
        rd(ssi_pkg::ADDR_FAULT_ACK, 8'h00);
        wr(ssi_pkg::ADDR_FAULT_MASK, 8'hff);
        chg(22, 1'b0, 1'b1);
        rd(ssi_pkg::ADDR_RAIL_HEALTH, 8'h01);
        // Every misc source: blocked by its mask bit, then alone unmasked
        for (int i = 0; i < 8; i++)
        begin
            idx = (i > 2) ? i + 7 : i;
            wr(ssi_pkg::ADDR_MISC_MASK, 8'hff);
            chg(idx, 1'b1, 1'b1);
            chg(idx, 1'b0, 1'b1);
            wr(ssi_pkg::ADDR_MISC_MASK, ~(8'h01 << i));
            chg(idx, 1'b1, 1'b0);
            rd(ssi_pkg::ADDR_MISC_ACK, 8'h01 << i);
            wr(ssi_pkg::ADDR_MISC_ACK, 8'h00);
            repeat (12) @(posedge clk_sys);
            cmp1(int_n, 1'b1, "misc release");
            wr(ssi_pkg::ADDR_MISC_MASK, 8'hff);
            chg(idx, 1'b0, 1'b1);
        end
        wrap_up();
    end
endmodule : tb

`default_nettype wire
